// >>> sim/dmec_dbg_model.sv
`timescale 1ns/1ps
module dmec_dbg_model
	import dmec_pkg::*;
(
	input  wire logic              clk,
	output logic                   en,
	output logic                   we,
	output logic                   rs,
	output logic [DSCR_W-1:0]      wd,
	output dmec_comp_t [3:0]       bk,
	output dmec_comp_t [3:0]       wp
);
	initial {en, we, rs, wd, bk, wp} = '0;
	task automatic dis();
		{bk, wp} = '0;
	endtask
	task automatic arm(input logic [31:0] a, input int i);
		bk[i] = {1'b1, a};
		wp[i] = {1'b1, a};
	endtask
	// A keep of 1 breaks the quiet-comparator order on purpose
	task automatic mode(input logic [1:0] m, input bit keep);
		if (!keep) dis();
		@(negedge clk);
		we = 1;
		wd = 32'(m) << MODE_LO_POS;
		@(negedge clk);
		we = 0;
		wd = ~wd;
	endtask
	task automatic set_en(input logic v);
		dis();
		@(negedge clk);
		en = v;
		repeat (3) @(negedge clk);
	endtask
	task automatic pulse();
		rs = 1;
		@(negedge clk);
		rs = 0;
	endtask
endmodule

// >>> sim/test_debug_mode_enable_control.sv
`timescale 1ns/1ps
module test_debug_mode_enable_control;
	import dmec_pkg::*;
	logic sys_clk, rst, we, en, rs, ret, ip, im, st, dc, he, me, it, md;
	logic [31:0] wd, sr;
	dmec_comp_t [3:0] bk, wp;
	dmec_access_t fe, da;
	int fail_count = 0, n_compared = 0;
	dmec_dbg_model m (.clk(sys_clk), .en(en), .we(we), .rs(rs), .wd(wd), .bk(bk), .wp(wp));
	dmec_debug_mode_ctrl uut (.sys_clk(sys_clk), .rst(rst), .invasive_debug_enable_in(en), .dscr_we(we),
		.dscr_wdata(wd), .debug_status_control_reg(sr), .bkpt_cmp(bk), .wpt_cmp(wp), .debug_restart(rs),
		.fetch(fe), .data_acc(da), .instr_retire(ret), .irq_pending(ip), .irq_masked(im), .core_stall(st),
		.data_commit(dc), .halt_event(he), .monitor_event(me), .irq_take(it), .match_discarded(md));
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string n, input logic [2:0] e, input logic [2:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic close_out();
		if (fail_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// One matched instruction; chg drops the modes while it is in flight
	task automatic run(input bit w, input logic [2:0] e, input bit chg);
		@(negedge sys_clk);
		if (w) da = {1'b1, 32'h0000_1230};
		else fe = {1'b1, 32'h0000_1230};
		#1 chk("data_commit", w, dc);
		@(negedge sys_clk);
		{fe, da} = '0;
		if (chg) m.mode(2'b00, 1);
		ret = 1;
		#1 chk("events", e, {he, me, md});
		@(negedge sys_clk);
		ret = 0;
		#1 chk("stall", e[2], st);
	endtask
	task automatic go_on();
		m.pulse();
		#1 chk("stall_rel", 0, st);
	endtask
	initial begin
		{rst, fe, da, ret, ip, im} = '0;
		rst = 1;
		repeat (8) @(negedge sys_clk);
		rst = 0;
		#1 chk("rst_stall", 0, st);
		chk("rst_mode", 0, sr[15:14]);
		m.set_en(1);
		m.mode(2'b10, 0);
		chk("mode", 2'b10, sr[15:14]);
		m.arm(32'h0000_1230, 0);
		run(0, 3'b100, 0);
		go_on();
		m.mode(2'b01, 0);
		m.arm(32'h0000_1230, 1);
		run(1, 3'b010, 0);
		m.mode(2'b11, 0);
		m.arm(32'h0000_1230, 2);
		run(0, 3'b100, 0);
		go_on();
		run(1, 3'b001, 1);
		m.mode(2'b10, 0);
		m.set_en(0);
		m.arm(32'h0000_1230, 3);
		run(0, 3'b000, 0);
		m.set_en(1);
		m.arm(32'h0000_1230, 1);
		run(0, 3'b100, 0);
		ip = 1;
		#1 chk("irq_held", 0, it);
		m.set_en(0);
		#1 chk("irq_take", 1, it);
		@(negedge sys_clk);
		im = 1;
		#1 chk("irq_masked", 0, it);
		close_out();
	end
	initial begin
		#20000;
		fail_count++;
		close_out();
	end
endmodule

// >>> src/dmec_debug_mode_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Halt and monitor modes are each enabled by one bit of the mode field [15:14] of the status/control word.
// - No debug event is raised while the synchronized copy of the invasive debug enable input is low.
// - Breakpoints match fetches and watchpoints match data accesses only when active, enabled and a mode is on.
// - Dropping the enable or the modes while a match is pending never deadlocks nor drops a data access.
// - A halt stall whose enable or modes have been dropped still lets an unmasked interrupt through.
module dmec_debug_mode_ctrl
	import dmec_pkg::*;
#(
	parameter int N_BKPT = NUM_BKPT,
	parameter int N_WPT  = NUM_WPT
) (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst,
	// Debugger side
	input  wire logic                     invasive_debug_enable_in,
	input  wire logic                     dscr_we,
	input  wire logic [DSCR_W-1:0]        dscr_wdata,
	output logic      [DSCR_W-1:0]        debug_status_control_reg,
	input  wire dmec_comp_t [N_BKPT-1:0]  bkpt_cmp,
	input  wire dmec_comp_t [N_WPT-1:0]   wpt_cmp,
	input  wire logic                     debug_restart,
	// Core side
	input  wire dmec_access_t             fetch,
	input  wire dmec_access_t             data_acc,
	input  wire logic                     instr_retire,
	input  wire logic                     irq_pending,
	input  wire logic                     irq_masked,
	output logic                          core_stall,
	output logic                          data_commit,
	output logic                          halt_event,
	output logic                          monitor_event,
	output logic                          irq_take,
	output logic                          match_discarded
);

	// Elaboration-time refusal of comparator counts the logic cannot serve
	if (N_BKPT < 1 || N_WPT < 1) begin : g_bad_count
		$error("Comparator counts must be at least one");
	end

	// Pin input synchronizer
	logic en_s1_reg, en_s2_reg;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			en_s1_reg <= 1'b0;
			en_s2_reg <= 1'b0;
		end else begin
			en_s1_reg <= invasive_debug_enable_in;
			en_s2_reg <= en_s1_reg;
		end
	end

	function automatic logic comp_hit(input dmec_comp_t c, input logic [ADDR_W-1:0] a);
		return c.active && (c.addr == a);
	endfunction

	logic [DSCR_W-1:0] dscr_reg, dscr_next;
	dmec_state_t       state_reg, state_next;
	logic              pend_wpt_reg, pend_wpt_next;
	logic              halt_on, mon_on, dbg_live, bk_hit, wp_hit;
	logic              bk_any, wp_any;

	// Any active comparator on the address counts; which one matched is not kept
	always_comb begin
		bk_any = 1'b0;
		wp_any = 1'b0;
		for (int i = 0; i < N_BKPT; i++)
			bk_any = bk_any | comp_hit(bkpt_cmp[i], fetch.addr);
		for (int i = 0; i < N_WPT; i++)
			wp_any = wp_any | comp_hit(wpt_cmp[i], data_acc.addr);
	end

	assign halt_on  = dscr_reg[MODE_HI_POS];
	assign mon_on   = dscr_reg[MODE_LO_POS];
	assign dbg_live = en_s2_reg && (halt_on || mon_on);
	assign bk_hit   = dbg_live && fetch.valid && bk_any;
	assign wp_hit   = dbg_live && data_acc.valid && wp_any;

	always_comb begin
		dscr_next        = dscr_we ? dscr_wdata : dscr_reg;
		state_next       = state_reg;
		pend_wpt_next    = pend_wpt_reg;
		halt_event       = 1'b0;
		monitor_event    = 1'b0;
		match_discarded  = 1'b0;
		case (state_reg)
			DMEC_IDLE: begin
				if (bk_hit || wp_hit) begin
					state_next    = DMEC_PENDING;
					pend_wpt_next = wp_hit;
				end
			end
			DMEC_PENDING: begin
				// Decision taken once, at retire, on the live enables
				if (instr_retire) begin
					if (!dbg_live) begin
						match_discarded = 1'b1;
						state_next      = DMEC_IDLE;
					end else if (halt_on) begin
						halt_event = 1'b1;
						state_next = DMEC_HALTED;
					end else begin
						monitor_event = 1'b1;
						state_next    = DMEC_IDLE;
					end
				end
			end
			DMEC_HALTED: begin
				if (debug_restart || !en_s2_reg)
					state_next = DMEC_IDLE;
			end
			default: state_next = DMEC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dscr_reg     <= DSCR_RESET;
			state_reg    <= DMEC_IDLE;
			pend_wpt_reg <= 1'b0;
		end else begin
			dscr_reg     <= dscr_next;
			state_reg    <= state_next;
			pend_wpt_reg <= pend_wpt_next;
		end
	end

	assign debug_status_control_reg = dscr_reg;
	// Only a halt stalls; a pending match lets the instruction run to retire
	assign core_stall  = (state_reg == DMEC_HALTED);
	// Data always commits, cancelled or not, so no access is lost
	assign data_commit = data_acc.valid;
	assign irq_take    = irq_pending && !irq_masked && (state_reg != DMEC_HALTED || !dbg_live);

	AST_NO_EVT_WHEN_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		!en_s2_reg |-> !(halt_event || monitor_event)) else $error("Debug event while disabled");

	AST_HIT_NEEDS_MODE: assert property (@(posedge sys_clk) disable iff (rst)
		(state_reg == DMEC_IDLE && state_next == DMEC_PENDING) |-> (halt_on || mon_on) && en_s2_reg)
		else $error("Match without mode");

	AST_HALT_MODE_BIT: assert property (@(posedge sys_clk) disable iff (rst)
		halt_event |-> dscr_reg[MODE_HI_POS]) else $error("Halt without halt mode");

	AST_MON_MODE_BIT: assert property (@(posedge sys_clk) disable iff (rst)
		monitor_event |-> dscr_reg[MODE_LO_POS] && !dscr_reg[MODE_HI_POS]) else $error("Monitor mode wrong");

	AST_DSCR_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
		dscr_we |=> debug_status_control_reg == $past(dscr_wdata)) else $error("Mode word not written");

	sequence s_halt_taken;
		halt_event;
	endsequence
	sequence s_halt_released;
		state_reg == DMEC_HALTED && debug_restart;
	endsequence

	AST_HALT_STALLS: assert property (@(posedge sys_clk) disable iff (rst)
		s_halt_taken |=> core_stall) else $error("Halt did not stall");

	AST_HALT_HOLDS: assert property (@(posedge sys_clk) disable iff (rst)
		(state_reg == DMEC_HALTED && !debug_restart && en_s2_reg) |=> core_stall) else $error("Halt left early");

	AST_RESTART_FREES: assert property (@(posedge sys_clk) disable iff (rst)
		s_halt_released |=> !core_stall) else $error("Restart did not release");

	AST_MON_NO_STALL: assert property (@(posedge sys_clk) disable iff (rst)
		monitor_event |=> !core_stall) else $error("Monitor event stalled");

	AST_NO_MATCH_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		!dbg_live |-> !(state_reg == DMEC_IDLE && state_next == DMEC_PENDING)) else $error("Match while off");

	// A pending watchpoint must never hold the core, or its access could be lost
	AST_WPT_NO_STALL: assert property (@(posedge sys_clk) disable iff (rst)
		(state_reg == DMEC_PENDING && pend_wpt_reg) |-> !core_stall) else $error("Watchpoint stalled core");

	AST_IRQ_PENDING: assert property (@(posedge sys_clk) disable iff (rst)
		(state_reg == DMEC_PENDING && irq_pending && !irq_masked) |-> irq_take) else $error("Irq refused");

	AST_MASKED_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
		irq_masked |-> !irq_take) else $error("Masked irq taken");

	AST_EVT_AT_RETIRE: assert property (@(posedge sys_clk) disable iff (rst)
		(halt_event || monitor_event || match_discarded) |-> (state_reg == DMEC_PENDING && instr_retire))
		else $error("Outcome outside retire");

	sequence s_pending_retire_off;
		state_reg == DMEC_PENDING && instr_retire && !dbg_live;
	endsequence
	AST_CANCEL_FREES: assert property (@(posedge sys_clk) disable iff (rst)
		s_pending_retire_off |=> state_reg == DMEC_IDLE && !core_stall) else $error("Cancelled match stuck");

	AST_NO_DEADLOCK: assert property (@(posedge sys_clk) disable iff (rst)
		(core_stall && !en_s2_reg) |-> ##[1:2] !core_stall) else $error("Stall held after disable");

	AST_DATA_KEPT: assert property (@(posedge sys_clk) disable iff (rst)
		data_acc.valid |-> data_commit) else $error("Data access dropped");

	AST_IRQ_SERVED: assert property (@(posedge sys_clk) disable iff (rst)
		(irq_pending && !irq_masked && !dbg_live) |-> irq_take) else $error("Unmasked irq refused");

	AST_ONE_OUTCOME: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg == DMEC_PENDING && instr_retire |-> $onehot({halt_event, monitor_event, match_discarded}))
		else $error("Pending match not resolved once");

endmodule

// >>> src/dmec_pkg.sv
package dmec_pkg;

	localparam int MODE_HI_POS  = 15;
	localparam int MODE_LO_POS  = 14;
	localparam int DSCR_W       = 32;
	localparam logic [31:0] DSCR_RESET = 32'h0000_0000;
	localparam int ADDR_W       = 32;
	localparam int NUM_BKPT     = 4;
	localparam int NUM_WPT      = 4;

	typedef enum logic [3:0] {
		DMEC_IDLE    = 4'b0001,
		DMEC_PENDING = 4'b0010,
		DMEC_HALTED  = 4'b0100,
		DMEC_MONITOR = 4'b1000
	} dmec_state_t;

	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
	} dmec_access_t;

	typedef struct packed {
		logic              active;
		logic [ADDR_W-1:0] addr;
	} dmec_comp_t;

endpackage
